// ---- pkg/bru_map.svh ----
`ifndef BRU_MAP_SVH
`define BRU_MAP_SVH

// Instruction word, program counter and branch offset widths
`define BRU_INSTR_W   16
`define BRU_PC_W      21
`define BRU_SHORT_W   8
`define BRU_LONG_W    11

// Opcode fields of the relative branches
`define BRU_COND_HI   4'he
`define BRU_OP_NC     4'h3
`define BRU_OP_NN     4'h7
`define BRU_OP_NOV    4'h5
`define BRU_OP_NZ     4'h1
`define BRU_ALW_HI    5'h1a

// Step past the one-word branch instruction, in bytes
`define BRU_PC_STEP   2

// Reset values
`define BRU_RST_PHASE 4'h1
`define BRU_RST_WORD  16'h0000

`endif

// ---- pkg/bru_pkg.sv ----
`default_nettype none
package bru_pkg;

  // Instruction cycle kind: normal execute or flushed no-operation
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b01,
    ST_FLUSH = 2'b10
  } cyc_state_e;

  // Decoded class of the word in the instruction register
  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_COND   = 2'h1,
    OP_ALWAYS = 2'h2
  } op_kind_e;

endpackage : bru_pkg
`default_nettype wire

// ---- logic/branch_target_calc.sv ----
`include "bru_map.svh"
`default_nettype none
module branch_target_calc #(
  parameter int PC_W = `BRU_PC_W
) (
  input  wire logic [PC_W-1:0]        base_addr,
  input  wire logic [`BRU_LONG_W-1:0] offset,
  output logic      [PC_W-1:0]        target
);

  logic [PC_W-1:0] off_ext;
  logic [PC_W-1:0] off_dbl;
  logic [PC_W-1:0] sum;

  // Sign extend, double, add the step; wraps at the counter width
  assign off_ext = {{(PC_W-`BRU_LONG_W){offset[`BRU_LONG_W-1]}}, offset};
  assign off_dbl = {off_ext[PC_W-2:0], 1'b0};
  assign sum     = base_addr + PC_W'(`BRU_PC_STEP) + off_dbl; // RULE6
  // Word aligned target even if the base address is odd
  assign target  = {sum[PC_W-1:1], 1'b0}; // RULE12

endmodule : branch_target_calc
`default_nettype wire

// ---- logic/relative_branch_unit.sv ----
// Overview of operation
// RULE1: Opcode e3 with 8-bit offset branches only when carry is clear.
// RULE2: Opcode e7 with 8-bit offset branches only when negative is clear.
// RULE3: Opcode e5 with 8-bit offset branches only when overflow is clear.
// RULE4: Opcode e1 with 8-bit offset branches only when zero is clear.
// RULE5: Short offset is signed, -128 to 127, and doubled before adding.
// RULE6: Target equals branch address plus two plus twice the offset.
// RULE7: Conditional branch takes one cycle untaken, two taken with flush.
// RULE8: Q1 decode, Q2 read offset, Q3 process, Q4 load PC if taken.
// RULE9: Unconditional branch decodes from 11010 plus 11-bit signed offset.
// RULE10: Unconditional branch always adds twice its offset, -1024 to 1023.
// RULE11: Unconditional branch always takes two cycles; every branch is one word.
// RULE12: Flags stay unchanged; target wraps at counter width with bit 0 zero.
`include "bru_map.svh"
`default_nettype none
module relative_branch_unit #(
  parameter int PC_W = `BRU_PC_W
) (
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic [`BRU_INSTR_W-1:0] instr_word,
  input  wire logic [PC_W-1:0]         instr_addr,
  input  wire logic                    carry_flag,
  input  wire logic                    negative_flag,
  input  wire logic                    overflow_flag,
  input  wire logic                    zero_flag,
  output logic      [3:0]              quarter_q,
  output logic                         pc_load_q,
  output logic      [PC_W-1:0]         pc_target_q,
  output logic                         branch_taken_q,
  output logic                         flush_q,
  output logic                         flag_hold_q
);

  // Classify a fetched word; other opcodes in the same row are not ours
  function automatic bru_pkg::op_kind_e decode_kind(
    input logic [`BRU_INSTR_W-1:0] w
  );
    logic cond_hit;
    cond_hit = (w[15:12] == `BRU_COND_HI) &&
               ((w[11:8] == `BRU_OP_NC)  || (w[11:8] == `BRU_OP_NN) ||
                (w[11:8] == `BRU_OP_NOV) || (w[11:8] == `BRU_OP_NZ));
    if (cond_hit) begin
      decode_kind = bru_pkg::OP_COND;
    end else if (w[15:11] == `BRU_ALW_HI) begin
      decode_kind = bru_pkg::OP_ALWAYS;
    end else begin
      decode_kind = bru_pkg::OP_NONE;
    end
  endfunction : decode_kind

  bru_pkg::cyc_state_e           state_q;
  bru_pkg::cyc_state_e           state_d;
  bru_pkg::op_kind_e             kind_q;
  bru_pkg::op_kind_e             kind_d;
  bru_pkg::op_kind_e             decoded;
  logic [`BRU_INSTR_W-1:0]       ir_q;
  logic [`BRU_INSTR_W-1:0]       ir_d;
  logic [PC_W-1:0]               addr_q;
  logic [PC_W-1:0]               addr_d;
  logic [`BRU_LONG_W-1:0]        off_q;
  logic [`BRU_LONG_W-1:0]        off_d;
  logic [`BRU_LONG_W-1:0]        short_ext;
  logic [PC_W-1:0]               calc_target;
  logic [PC_W-1:0]               pc_target_d;
  logic [3:0]                    quarter_d;
  logic                          q1;
  logic                          q2;
  logic                          q3;
  logic                          q4;
  logic                          cond_flag;
  logic                          take_d;
  logic                          pc_load_d;
  logic                          branch_taken_d;
  logic                          flush_d;
  logic                          flag_hold_d;

  // Four quarter phases rotate continuously
  assign q1        = quarter_q[0];
  assign q2        = quarter_q[1];
  assign q3        = quarter_q[2];
  assign q4        = quarter_q[3];
  assign quarter_d = {quarter_q[2:0], quarter_q[3]};

  // Q1: decode; in a flush cycle the prefetched word is thrown away
  assign decoded = decode_kind(instr_word); // RULE9
  assign kind_d  = !q1 ? kind_q :
                   (state_q == bru_pkg::ST_EXEC) ? decoded : bru_pkg::OP_NONE; // RULE8
  assign ir_d    = q1 ? instr_word : ir_q;
  assign addr_d  = q1 ? instr_addr : addr_q;

  // Q2: read the literal; short form is sign extended to the long width
  assign short_ext = {{(`BRU_LONG_W-`BRU_SHORT_W){ir_q[`BRU_SHORT_W-1]}},
                      ir_q[`BRU_SHORT_W-1:0]}; // RULE5
  assign off_d     = !q2 ? off_q :
                     (kind_q == bru_pkg::OP_COND) ? short_ext
                                                  : ir_q[`BRU_LONG_W-1:0]; // RULE10

  // Q3: pick the tested flag from the opcode and decide
  assign cond_flag = (ir_q[11:8] == `BRU_OP_NC)  ? carry_flag :    // RULE1
                     (ir_q[11:8] == `BRU_OP_NN)  ? negative_flag : // RULE2
                     (ir_q[11:8] == `BRU_OP_NOV) ? overflow_flag : // RULE3
                     zero_flag;                                    // RULE4
  assign take_d    = (kind_q == bru_pkg::OP_ALWAYS) ||
                     ((kind_q == bru_pkg::OP_COND) && !cond_flag); // RULE11

  // Shared adder; the result is only latched at the end of Q3
  branch_target_calc #(
    .PC_W      (PC_W)
  ) u_target (
    .base_addr (addr_q),
    .offset    (off_q),
    .target    (calc_target)
  );

  assign pc_target_d    = q3 ? calc_target : pc_target_q; // RULE6
  assign pc_load_d      = q3 && take_d; // RULE8
  assign branch_taken_d = q3 ? take_d : branch_taken_q;

  // Q4 closes the cycle; a load turns the next cycle into a flush
  assign state_d = !q4 ? state_q :
                   ((state_q == bru_pkg::ST_EXEC) && pc_load_q) ? bru_pkg::ST_FLUSH
                                                                 : bru_pkg::ST_EXEC; // RULE7
  assign flush_d = (state_d == bru_pkg::ST_FLUSH);

  // Tells the ALU to keep its flags while a branch or its flush runs
  assign flag_hold_d = (kind_d != bru_pkg::OP_NONE) || flush_d; // RULE12

  // Phase and state registers
  always_ff @(posedge clock) begin
    if (srst) begin
      quarter_q <= `BRU_RST_PHASE;
      state_q   <= bru_pkg::ST_EXEC;
      flush_q   <= 1'b0;
    end else begin
      quarter_q <= quarter_d;
      state_q   <= state_d;
      flush_q   <= flush_d;
    end
  end

  // Instruction, address and offset capture
  always_ff @(posedge clock) begin
    if (srst) begin
      kind_q <= bru_pkg::OP_NONE;
      ir_q   <= `BRU_RST_WORD;
      addr_q <= '0;
      off_q  <= '0;
    end else begin
      kind_q <= kind_d;
      ir_q   <= ir_d;
      addr_q <= addr_d;
      off_q  <= off_d;
    end
  end

  // Result registers for the program counter load and target, the taken status and the ALU flag hold
  always_ff @(posedge clock) begin
    if (srst) begin
      pc_load_q      <= 1'b0;
      pc_target_q    <= '0;
      branch_taken_q <= 1'b0;
      flag_hold_q    <= 1'b0;
    end else begin
      pc_load_q      <= pc_load_d;
      pc_target_q    <= pc_target_d;
      branch_taken_q <= branch_taken_d;
      flag_hold_q    <= flag_hold_d;
    end
  end

  // Checks on the sequencing and the arithmetic
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence s_load;
    pc_load_q && q4;
  endsequence

  sequence s_flush_cycle;
    (flush_q && !pc_load_q) [*4];
  endsequence

  phase_ring_ok_a: assert property ($onehot(quarter_q))
    else $error("quarter phase not one-hot");

  load_in_q4_a: assert property (pc_load_q |-> q4) // RULE8
    else $error("pc load outside Q4");

  carry_clear_take_a: assert property ( // RULE1
    (q3 && kind_q == bru_pkg::OP_COND && ir_q[11:8] == `BRU_OP_NC)
      |=> pc_load_q == !$past(carry_flag))
    else $error("carry branch decision wrong");

  neg_clear_take_a: assert property ( // RULE2
    (q3 && kind_q == bru_pkg::OP_COND && ir_q[11:8] == `BRU_OP_NN)
      |=> pc_load_q == !$past(negative_flag))
    else $error("negative branch decision wrong");

  ovf_clear_take_a: assert property ( // RULE3
    (q3 && kind_q == bru_pkg::OP_COND && ir_q[11:8] == `BRU_OP_NOV)
      |=> pc_load_q == !$past(overflow_flag))
    else $error("overflow branch decision wrong");

  zero_clear_take_a: assert property ( // RULE4
    (q3 && kind_q == bru_pkg::OP_COND && ir_q[11:8] == `BRU_OP_NZ)
      |=> pc_load_q == !$past(zero_flag))
    else $error("zero branch decision wrong");

  short_offset_ext_a: assert property ( // RULE5
    (q3 && kind_q == bru_pkg::OP_COND)
      |-> $signed(off_q) == $signed(ir_q[`BRU_SHORT_W-1:0]))
    else $error("short offset not sign extended");

  // Bit 0 is masked: an odd fetch address still gives a word aligned target
  target_value_a: assert property ( // RULE6
    q3 ##1 pc_load_q |-> pc_target_q ==
      (PC_W'($past(addr_q) + PC_W'(`BRU_PC_STEP) +
             {{(PC_W-`BRU_LONG_W){$past(off_q[`BRU_LONG_W-1])}}, $past(off_q), 1'b0})
       & {{(PC_W-1){1'b1}}, 1'b0}))
    else $error("branch target wrong");

  taken_flush_a: assert property (s_load |=> s_flush_cycle ##1 !flush_q) // RULE7
    else $error("taken branch flush not one cycle");

  untaken_no_flush_a: assert property ( // RULE7
    (q4 && kind_q == bru_pkg::OP_COND && !pc_load_q) |=> !flush_q [*4])
    else $error("untaken branch flushed");

  always_decode_a: assert property ( // RULE9
    (q1 && state_q == bru_pkg::ST_EXEC && instr_word[15:11] == `BRU_ALW_HI)
      |=> kind_q == bru_pkg::OP_ALWAYS ##2 pc_load_q)
    else $error("unconditional branch not decoded or not taken");

  flush_kills_decode_a: assert property ( // RULE11
    (q1 && flush_q) |=> kind_q == bru_pkg::OP_NONE [*3] ##1 !pc_load_q)
    else $error("flush cycle executed an instruction");

  flag_hold_even_a: assert property ( // RULE12
    (kind_q != bru_pkg::OP_NONE || flush_q) |-> flag_hold_q && !pc_target_q[0])
    else $error("flags not held or odd target");

endmodule : relative_branch_unit
`default_nettype wire

// ---- dv/relative_branch_unit_bench.sv ----
`default_nettype none
module relative_branch_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PCW = 21;
  // Flags packed as carry, negative, overflow, zero
  typedef struct packed {
    logic [15:0]    word;
    logic [PCW-1:0] addr;
    logic [3:0]     flg;
    logic           br;
    logic           tk;
  } row_s;
  logic           clock      = 1'b0;
  logic           srst       = 1'b1;
  logic [15:0]    instr_word = 16'h0000;
  logic [PCW-1:0] instr_addr = 21'h0;
  logic [3:0]     flg        = 4'h0;
  logic [3:0]     quarter_q;
  logic           pc_load_q;
  logic [PCW-1:0] pc_target_q;
  logic           branch_taken_q;
  logic           flush_q;
  logic           flag_hold_q;
  int             miscompares = 0;
  int             checked     = 0;
  row_s rows [17] = '{
    '{16'he305, 21'h000100, 4'h0, 1'b1, 1'b1}, '{16'he3ff, 21'h000100, 4'h8, 1'b1, 1'b0},
    '{16'he380, 21'h000200, 4'h7, 1'b1, 1'b1}, '{16'he77f, 21'h001000, 4'hb, 1'b1, 1'b1},
    '{16'he701, 21'h001000, 4'h4, 1'b1, 1'b0}, '{16'he510, 21'h000400, 4'hd, 1'b1, 1'b1},
    '{16'he5f0, 21'h000400, 4'h2, 1'b1, 1'b0}, '{16'he1c0, 21'h000800, 4'he, 1'b1, 1'b1},
    '{16'he122, 21'h000800, 4'h1, 1'b1, 1'b0}, '{16'hd3ff, 21'h000040, 4'hf, 1'b1, 1'b1},
    '{16'hd400, 21'h000000, 4'hf, 1'b1, 1'b1}, '{16'he37f, 21'h1ffffe, 4'h7, 1'b1, 1'b1},
    '{16'he300, 21'h000101, 4'h0, 1'b1, 1'b1}, '{16'he205, 21'h000100, 4'h0, 1'b0, 1'b0},
    '{16'he605, 21'h000100, 4'h0, 1'b0, 1'b0}, '{16'hd805, 21'h000100, 4'hf, 1'b0, 1'b0},
    '{16'h0000, 21'h000100, 4'h0, 1'b0, 1'b0}};

  relative_branch_unit #(.PC_W(PCW)) u_relative_branch_unit (
    .clock(clock), .srst(srst), .instr_word(instr_word), .instr_addr(instr_addr),
    .carry_flag(flg[3]), .negative_flag(flg[2]), .overflow_flag(flg[1]), .zero_flag(flg[0]),
    .quarter_q(quarter_q), .pc_load_q(pc_load_q), .pc_target_q(pc_target_q),
    .branch_taken_q(branch_taken_q), .flush_q(flush_q), .flag_hold_q(flag_hold_q));

  always #10 clock = ~clock;

  // Long form offset for the always branch, short form otherwise
  function automatic logic [PCW-1:0] target_of(input logic [15:0] w, input logic [PCW-1:0] a);
    logic [PCW-1:0] off;
    off = (w[15:11] == 5'h1a) ? PCW'($signed(w[10:0])) : PCW'($signed(w[7:0]));
    target_of = (a + 21'h2 + (off << 1)) & ~21'h1;
  endfunction : target_of

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Reads values settled after the reset edge
  task automatic rst_check;
    check("reset state", {quarter_q, pc_load_q, branch_taken_q, flush_q, flag_hold_q}, 8'h10);
    check("reset target", pc_target_q, 32'h0);
  endtask : rst_check

  // Presents one word for the next normal Q1; flags f1 early, f3 for Q3
  task automatic run(input logic [15:0] w, input logic [PCW-1:0] a, input logic [3:0] f1,
                     input logic [3:0] f3, input logic br, input logic tk);
    while (!(quarter_q === 4'h8 && pc_load_q !== 1'b1)) @(posedge clock);
    instr_word <= w;
    instr_addr <= a;
    flg        <= f1;
    @(posedge clock);
    instr_word <= ~w;  // Outside Q1 the word must not matter
    @(posedge clock);
    check("quarter_q", quarter_q, 4'h2);
    check("flag_hold_q", flag_hold_q, br);
    flg <= f3;
    @(posedge clock);
    check("early load", {pc_load_q, flush_q}, 2'b00);
    flg <= ~f3;  // Late flag change must not count
    @(posedge clock);
    check("pc_load_q", pc_load_q, tk);
    check("branch_taken_q", branch_taken_q, tk);
    if (br) check("pc_target_q", pc_target_q, target_of(w, a));
    if (tk) begin
      instr_word <= 16'hd010;  // A branch word in the flush Q1 is dropped
      repeat (4) begin
        @(posedge clock);
        check("flush", {flush_q, pc_load_q, flag_hold_q}, 3'b101);
      end
    end
  endtask : run

  initial begin
    repeat (2) @(posedge clock);
    rst_check();
    srst <= 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      run(rows[i].word, rows[i].addr, rows[i].flg, rows[i].flg, rows[i].br, rows[i].tk);
      $display("row %0d done", i);
    end
    // Carry set during Q1 but clear at the end of Q3
    run(16'he305, 21'h000100, 4'h8, 4'h0, 1'b1, 1'b1);
    $display("flag timing test done");
    // Reset in the middle of a flush cycle, then recovery
    while (!(quarter_q === 4'h8 && pc_load_q !== 1'b1)) @(posedge clock);
    instr_word <= 16'hd005;
    repeat (5) @(posedge clock);
    srst       <= 1'b1;
    instr_word <= 16'h0000;
    repeat (2) @(posedge clock);
    rst_check();
    srst <= 1'b0;
    run(16'he1fe, 21'h000300, 4'h0, 4'h0, 1'b1, 1'b1);
    $display("mid-run reset test done");
    final_report();
  end

  // Whole run is some 140 clocks; this cuts a hang well after that
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    final_report();
  end
endmodule : relative_branch_unit_bench
`default_nettype wire
